// ---- logic/hldc_ctrl.sv ----
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hldc_ctrl #(
    parameter int STEP_DOWN_CYCLES = hldc_pkg::STEP_DOWN_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic plugDetectPin,
    input wire logic resAbove300Pin,
    input wire logic resAbove22Pin,
    input wire logic capHighPin,
    input wire logic clipPresentPin,
    input wire logic clipLowerPin,
    input wire logic fsClockPin,
    input wire logic pumpClockPin,
    output logic toneOutA,
    output logic toneEnable,
    output logic senseContactFour,
    output logic capMeasureActive,
    output logic [1:0] railMode,
    output logic [7:0] mixerVolume,
    output logic [7:0] dacVolume,
    output logic [7:0] hpVolume
);
    localparam int NPIN = 8;

    hldc_pkg::hldc_ctrl_type ctrl;
    logic [23:0] volumeTarget;
    hldc_pkg::hldc_status_type status;
    hldc_pkg::hldc_det_type detState;
    hldc_pkg::hldc_det_type next_detState;

    // two-flop synchronisers; the first stage feeds only the second
    logic [NPIN-1:0] pinMeta;
    logic [NPIN-1:0] pinSync;
    logic [NPIN-1:0] pinPrev;
    wire [NPIN-1:0] pinRaw = {pumpClockPin, fsClockPin, clipLowerPin, clipPresentPin,
                              capHighPin, resAbove22Pin, resAbove300Pin, plugDetectPin};

    always_ff @(posedge clock) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
            pinPrev <= '0;
        end else if (clockEnable) begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    wire plugRise = pinSync[0] && !pinPrev[0];
    wire resAbove300 = pinSync[1];
    wire resAbove22 = pinSync[2];
    wire capHigh = pinSync[3];
    wire clipPresent = pinSync[4];
    wire clipLower = pinSync[5];
    wire fsTick = pinSync[6] && !pinPrev[6];
    wire pumpTick = pinSync[7] && !pinPrev[7];

    // APB: setup edge latches answer, access phase completes with pready high
    wire setupPhase = psel && !penable && !pready;
    wire accessDone = psel && penable && pready;
    wire hitCtrl = (paddr == hldc_pkg::CTRL_OFFSET);
    wire hitVolume = (paddr == hldc_pkg::VOLUME_OFFSET);
    wire hitStatus = (paddr == hldc_pkg::STATUS_OFFSET);
    wire hitLevel = (paddr == hldc_pkg::LEVEL_OFFSET);
    wire hitAny = hitCtrl || hitVolume || hitStatus || hitLevel;
    wire writeCtrl = accessDone && pwrite && hitCtrl;
    wire writeVolume = accessDone && pwrite && hitVolume;
    wire writeStatus = accessDone && pwrite && hitStatus;
    wire clearDone = writeStatus && pwdata[hldc_pkg::STATUS_DONE_BIT];

    wire [31:0] readMux;
    assign readMux = hitCtrl ? {16'h0000, ctrl} :
                     hitVolume ? {8'h00, volumeTarget} :
                     hitStatus ? {25'h0000000, railMode, status} :
                     hitLevel ? {8'h00, hpVolume, dacVolume, mixerVolume} :
                     32'h00000000;

    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clockEnable) begin
            if (setupPhase) begin
                pready <= 1'b1;
                pslverr <= !hitAny;
                prdata <= pwrite ? 32'h00000000 : readMux;
            end else if (accessDone) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= hldc_pkg::CTRL_RESET;
            volumeTarget <= hldc_pkg::VOLUME_RESET;
        end else if (clockEnable) begin
            if (writeCtrl) begin
                ctrl <= pwdata[15:0];
            end
            if (writeVolume) begin
                volumeTarget <= pwdata[23:0];
            end
        end
    end

    // load detection sequence
    logic [11:0] measCount;
    wire resEnd = (measCount == 12'(hldc_pkg::RES_MEAS_CYCLES - 1));
    wire capEnd = (measCount == 12'(hldc_pkg::CAP_MEAS_CYCLES - 1));
    wire [1:0] resClass = resAbove300 ? hldc_pkg::RES_3K :
                          resAbove22 ? hldc_pkg::RES_30 :
                          hldc_pkg::RES_15;
    wire startDetect = plugRise && ctrl.loadDetectEnable;

    always_comb begin
        next_detState = detState;
        case (detState)
            hldc_pkg::DET_IDLE: begin
                if (startDetect) begin
                    next_detState = hldc_pkg::DET_RES;
                end
            end
            hldc_pkg::DET_RES: begin
                if (resEnd) begin
                    // low resistance loads are taken as low capacitance
                    next_detState = (resClass == hldc_pkg::RES_3K) ?
                                    hldc_pkg::DET_CAP : hldc_pkg::DET_DONE;
                end
            end
            hldc_pkg::DET_CAP: begin
                if (capEnd) begin
                    next_detState = hldc_pkg::DET_DONE;
                end
            end
            hldc_pkg::DET_DONE: begin
                next_detState = hldc_pkg::DET_IDLE;
            end
            default: begin
                next_detState = hldc_pkg::DET_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            detState <= hldc_pkg::DET_IDLE;
            measCount <= 12'h000;
        end else if (clockEnable) begin
            detState <= next_detState;
            if (next_detState != detState) begin
                measCount <= 12'h000;
            end else if (detState == hldc_pkg::DET_RES || detState == hldc_pkg::DET_CAP) begin
                measCount <= measCount + 12'h001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status <= '0;
        end else if (clockEnable) begin
            status.busy <= (next_detState != hldc_pkg::DET_IDLE);
            if (startDetect && detState == hldc_pkg::DET_IDLE) begin
                status.resStatus <= hldc_pkg::RES_15;
                status.capHigh <= 1'b0;
            end
            if (detState == hldc_pkg::DET_RES && resEnd) begin
                status.resStatus <= resClass;
                status.capHigh <= 1'b0;
            end
            if (detState == hldc_pkg::DET_CAP && capEnd) begin
                status.capHigh <= capHigh;
            end
            // a completion in the clearing cycle keeps the flag set
            if (detState == hldc_pkg::DET_DONE) begin
                status.done <= 1'b1;
            end else if (clearDone || (startDetect && detState == hldc_pkg::DET_IDLE)) begin
                status.done <= 1'b0;
            end
        end
    end

    // measurement tone and contact sense
    logic [9:0] toneCount;
    wire measuring = (detState == hldc_pkg::DET_RES) || (detState == hldc_pkg::DET_CAP);
    wire toneFlip = (toneCount == 10'(hldc_pkg::TONE_HALF_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (rst) begin
            toneCount <= 10'h000;
            toneOutA <= 1'b0;
            toneEnable <= 1'b0;
            senseContactFour <= 1'b0;
            capMeasureActive <= 1'b0;
        end else if (clockEnable) begin
            toneEnable <= measuring;
            senseContactFour <= ctrl.contactFour;
            capMeasureActive <= (detState == hldc_pkg::DET_CAP);
            if (!measuring) begin
                toneCount <= 10'h000;
                toneOutA <= 1'b0;
            end else if (toneFlip) begin
                toneCount <= 10'h000;
                toneOutA <= !toneOutA;
            end else begin
                toneCount <= toneCount + 10'h001;
            end
        end
    end

    // soft ramping of volumes
    wire rampOn = (ctrl.slowStart == hldc_pkg::SLOW_START_ON);
    wire [6:0] digitalDelay = hldc_pkg::hldc_ramp_delay(ctrl.digitalRampRate);
    wire [6:0] analogDelay = hldc_pkg::hldc_ramp_delay(ctrl.analogRampRate);

    hldc_soft_ramp mixerRamp (
        .clock(clock),
        .rst(rst),
        .clockEnable(clockEnable),
        .rampOn(rampOn),
        .fsTick(fsTick),
        .stepDelay(digitalDelay),
        .target(volumeTarget[7:0]),
        .level(mixerVolume)
    );

    hldc_soft_ramp dacRamp (
        .clock(clock),
        .rst(rst),
        .clockEnable(clockEnable),
        .rampOn(rampOn),
        .fsTick(fsTick),
        .stepDelay(digitalDelay),
        .target(volumeTarget[15:8]),
        .level(dacVolume)
    );

    // headphone gain is analog, so it follows the analog rate
    hldc_soft_ramp hpRamp (
        .clock(clock),
        .rst(rst),
        .clockEnable(clockEnable),
        .rampOn(rampOn),
        .fsTick(fsTick),
        .stepDelay(analogDelay),
        .target(volumeTarget[23:16]),
        .level(hpVolume)
    );

    // class H rail selection
    logic [27:0] holdCount;
    logic upPending;
    logic [1:0] fixedMode;
    wire adaptive = (ctrl.railPowerSelect == hldc_pkg::RAIL_ADAPTIVE);
    wire holdExpired = (holdCount == 28'(STEP_DOWN_CYCLES - 1));
    wire canStepUp = (railMode != hldc_pkg::MODE_2V5);
    wire canStepDown = (railMode != hldc_pkg::MODE_THIRD);

    always_comb begin
        case (ctrl.railPowerSelect)
            hldc_pkg::RAIL_FIXED_25: fixedMode = hldc_pkg::MODE_2V5;
            hldc_pkg::RAIL_FIXED_FULL: fixedMode = hldc_pkg::MODE_FULL;
            hldc_pkg::RAIL_FIXED_HALF: fixedMode = hldc_pkg::MODE_HALF;
            hldc_pkg::RAIL_FIXED_THIRD: fixedMode = hldc_pkg::MODE_THIRD;
            default: fixedMode = hldc_pkg::MODE_2V5;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            railMode <= hldc_pkg::MODE_2V5;
            holdCount <= 28'h0000000;
            upPending <= 1'b0;
        end else if (clockEnable) begin
            if (!adaptive) begin
                railMode <= fixedMode;
                holdCount <= 28'h0000000;
                upPending <= 1'b0;
            end else if (clipPresent && canStepUp) begin
                // higher rails are waited for only until the pump switches
                holdCount <= 28'h0000000;
                if (pumpTick || upPending) begin
                    if (pumpTick) begin
                        railMode <= railMode - 2'h1;
                        upPending <= 1'b0;
                    end
                end else begin
                    upPending <= 1'b1;
                end
            end else if (clipPresent || clipLower || !canStepDown) begin
                holdCount <= 28'h0000000;
                upPending <= 1'b0;
            end else if (holdExpired) begin
                railMode <= railMode + 2'h1;
                holdCount <= 28'h0000000;
                upPending <= 1'b0;
            end else begin
                holdCount <= holdCount + 28'h0000001;
                upPending <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/hldc_pkg.sv ----
`default_nettype none
package hldc_pkg;
    localparam int CLOCK_HZ = 40000000;
    localparam int TONE_HZ = 24000;
    localparam int TONE_HALF_CYCLES = CLOCK_HZ / (2 * TONE_HZ);
    localparam int STEP_DOWN_HOLD_MS = 5500;
    localparam int STEP_DOWN_HOLD_CYCLES = STEP_DOWN_HOLD_MS * (CLOCK_HZ / 1000);
    localparam int RES_MEAS_CYCLES = 4000;
    localparam int CAP_MEAS_CYCLES = 4000;
    localparam int VOL_W = 8;
    localparam int ADDR_W = 12;

    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] VOLUME_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] LEVEL_OFFSET = 12'h00c;

    localparam int STATUS_DONE_BIT = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0010;
    localparam logic [23:0] VOLUME_RESET = 24'h000000;

    localparam logic [2:0] SLOW_START_ON = 3'h7;
    localparam logic [2:0] RAIL_FIXED_25 = 3'h1;
    localparam logic [2:0] RAIL_FIXED_FULL = 3'h2;
    localparam logic [2:0] RAIL_FIXED_HALF = 3'h3;
    localparam logic [2:0] RAIL_FIXED_THIRD = 3'h4;
    localparam logic [2:0] RAIL_ADAPTIVE = 3'h7;

    localparam logic [1:0] MODE_2V5 = 2'h0;
    localparam logic [1:0] MODE_FULL = 2'h1;
    localparam logic [1:0] MODE_HALF = 2'h2;
    localparam logic [1:0] MODE_THIRD = 2'h3;

    localparam logic [1:0] RES_15 = 2'h0;
    localparam logic [1:0] RES_30 = 2'h1;
    localparam logic [1:0] RES_3K = 2'h2;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b00,
        DET_RES = 2'b01,
        DET_CAP = 2'b11,
        DET_DONE = 2'b10
    } hldc_det_type;

    typedef struct packed {
        logic [3:0] digitalRampRate;
        logic [3:0] analogRampRate;
        logic contactFour;
        logic [2:0] railPowerSelect;
        logic [2:0] slowStart;
        logic loadDetectEnable;
    } hldc_ctrl_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic capHigh;
        logic [1:0] resStatus;
    } hldc_status_type;

    // step delay in sample periods, spanning 1 to 72
    function automatic logic [6:0] hldc_ramp_delay(input logic [3:0] code);
        logic [6:0] d;
        d = 7'h01;
        case (code)
            4'h0: d = 7'h01;
            4'h1: d = 7'h02;
            4'h2: d = 7'h03;
            4'h3: d = 7'h04;
            4'h4: d = 7'h06;
            4'h5: d = 7'h08;
            4'h6: d = 7'h0c;
            4'h7: d = 7'h10;
            4'h8: d = 7'h18;
            4'h9: d = 7'h20;
            4'ha: d = 7'h28;
            4'hb: d = 7'h30;
            4'hc: d = 7'h38;
            4'hd: d = 7'h40;
            default: d = 7'h48;
        endcase
        return d;
    endfunction
endpackage
`default_nettype wire

// ---- logic/hldc_soft_ramp.sv ----
`timescale 1ns/1ps
`default_nettype none
module hldc_soft_ramp (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    input wire logic rampOn,
    input wire logic fsTick,
    input wire logic [6:0] stepDelay,
    input wire logic [7:0] target,
    output logic [7:0] level
);
    logic [6:0] waitCount;
    wire atTarget = (level == target);
    wire stepDue = fsTick && (waitCount + 7'h01 >= stepDelay);
    wire [7:0] stepped = (level < target) ? level + 8'h01 : level - 8'h01;

    always_ff @(posedge clock) begin
        if (rst) begin
            level <= 8'h00;
            waitCount <= 7'h00;
        end else if (clockEnable) begin
            if (!rampOn) begin
                level <= target;
                waitCount <= 7'h00;
            end else if (atTarget) begin
                waitCount <= 7'h00;
            end else if (stepDue) begin
                level <= stepped;
                waitCount <= 7'h00;
            end else if (fsTick) begin
                waitCount <= waitCount + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/hldc_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module hldc_ctrl_checker #(
    parameter int STEP_DOWN_CYCLES = 50
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic resAbove300Pin,
    input wire logic clipPresentPin,
    input wire logic clipLowerPin,
    input wire logic toneEnable,
    input wire logic senseContactFour,
    input wire logic capMeasureActive,
    input wire logic [1:0] railMode,
    input wire logic [7:0] mixerVolume,
    input wire logic [7:0] dacVolume,
    input wire logic [7:0] hpVolume
);
    logic [15:0] shCtrl;
    logic [23:0] shVol;
    logic clipSeen;
    logic [1:0] prevMode;
    int quietCnt;
    int upWait;
    wire wrDone = psel && penable && pready && pwrite && !pslverr;
    wire adaptive = shCtrl[6:4] == hldc_pkg::RAIL_ADAPTIVE;
    wire ramping = shCtrl[3:1] == hldc_pkg::SLOW_START_ON;

    always_ff @(posedge clock) begin
        if (rst) begin
            shCtrl <= hldc_pkg::CTRL_RESET;
            shVol <= hldc_pkg::VOLUME_RESET;
        end else if (wrDone && paddr == hldc_pkg::CTRL_OFFSET) begin
            shCtrl <= pwdata[15:0];
        end else if (wrDone && paddr == hldc_pkg::VOLUME_OFFSET) begin
            shVol <= pwdata[23:0];
        end
    end

    // one flop behind the pins, so this count never trails the design's
    always_ff @(posedge clock) begin
        clipSeen <= clipPresentPin || clipLowerPin;
        prevMode <= railMode;
        if (rst || clipSeen) begin
            quietCnt <= 0;
        end else if (quietCnt < STEP_DOWN_CYCLES) begin
            quietCnt <= quietCnt + 1;
        end
        if (rst || !adaptive || !clipPresentPin || railMode != prevMode || railMode == 2'h0) begin
            upWait <= 0;
        end else begin
            upWait <= upWait + 1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    apb_answer_a: assert property (psel && !penable && !pready |=> pready ##1 !pready)
        else $error("apb access length wrong");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("slave error outside access");
    // rail mode follows the select one cycle late, so wait for a settled select
    fixed_rail_a: assert property ((shCtrl[6:4] inside {[3'h1:3'h4]}
        && $stable(shCtrl[6:4]))[*2]
        |-> railMode == 2'(shCtrl[6:4] - 3'h1)) else $error("fixed rail mode wrong");
    step_up_a: assert property (upWait < 20)
        else $error("rail step up too late");
    step_down_a: assert property (adaptive && $past(adaptive)
        && railMode > $past(railMode) |-> quietCnt >= STEP_DOWN_CYCLES)
        else $error("rails lowered before hold ran out");
    contact_copy_a: assert property (shCtrl[7] == $past(shCtrl[7])
        |-> senseContactFour == shCtrl[7]) else $error("sense contact wrong");
    vol_direct_a: assert property ((!ramping && $stable(shVol))[*2]
        |-> {hpVolume, dacVolume, mixerVolume} == shVol) else $error("volume not direct");
    ramp_step_a: assert property (ramping && $past(ramping)
        |-> mixerVolume == $past(mixerVolume) || mixerVolume == $past(mixerVolume) + 8'h01
        || mixerVolume == $past(mixerVolume) - 8'h01) else $error("ramp step not one");
    detect_gate_a: assert property ($rose(toneEnable) |-> shCtrl[0])
        else $error("detection started while disabled");
    cap_gate_a: assert property ($rose(capMeasureActive) |-> resAbove300Pin && toneEnable)
        else $error("capacitance phase on low resistance");

    cover property ($rose(capMeasureActive));
    cover property (adaptive && railMode < $past(railMode));
    cover property (adaptive && railMode > $past(railMode));
    cover property (pslverr);
endmodule
bind hldc_ctrl hldc_ctrl_checker #(.STEP_DOWN_CYCLES(STEP_DOWN_CYCLES)) chk (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .resAbove300Pin, .clipPresentPin, .clipLowerPin, .toneEnable, .senseContactFour,
    .capMeasureActive, .railMode, .mixerVolume, .dacVolume, .hpVolume
);
`default_nettype wire

// ---- testbench/hldc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hldc_ctrl_tb_top;
    localparam int SD = 50;
    localparam int DLY[16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 40, 48, 56, 64, 72, 72};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clockEnable = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic plugDetectPin = 1'b0;
    logic resAbove300Pin = 1'b0;
    logic resAbove22Pin = 1'b0;
    logic capHighPin = 1'b0;
    logic clipPresentPin = 1'b0;
    logic clipLowerPin = 1'b0;
    logic fsClockPin = 1'b0;
    logic pumpClockPin = 1'b0;
    logic [31:0] prdata, rd, v, c, e;
    logic pready, pslverr, err, toneOutA, toneEnable, senseContactFour, capMeasureActive;
    logic [1:0] railMode;
    logic [7:0] mixerVolume, dacVolume, hpVolume;
    logic [31:0] seed = 32'h00008aae;
    int errors = 0;
    int nCompared = 0;
    int tick = 0;
    int t;
    int d;

    hldc_ctrl #(.STEP_DOWN_CYCLES(SD)) dut (
        .clock, .rst, .clockEnable, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .plugDetectPin, .resAbove300Pin, .resAbove22Pin,
        .capHighPin, .clipPresentPin, .clipLowerPin, .fsClockPin, .pumpClockPin,
        .toneOutA, .toneEnable, .senseContactFour, .capMeasureActive, .railMode,
        .mixerVolume, .dacVolume, .hpVolume
    );

    initial forever #12.5 clock = ~clock;

    // fast sample and pump clocks keep the longest ramp code short
    always @(posedge clock) begin
        tick <= tick + 1;
        fsClockPin <= tick[2];
        pumpClockPin <= (tick % 6) < 3;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tic();
        @(posedge clock);
        t++;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clock);
        penable <= 1'b1;
        t = 0;
        do tic(); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'(pready), 32'h1);
    endtask

    task automatic end_sim();
        $display("compared %0d errors %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, hldc_pkg::LEVEL_OFFSET, rnd());
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", rd, i == 0 ? {16'h0000, hldc_pkg::CTRL_RESET} : 32'h0);
        end
        apb(1'b1, 12'h7fc, rnd());
        chk("unmapped write", 32'(err), 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped read", {rd[31:1], err}, 32'h1);
        // clip held high: fixed codes must ignore it
        clipPresentPin <= 1'b1;
        clipLowerPin <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            v = rnd();
            c = {16'h0000, v[15:7], 3'(k), 4'h0};
            apb(1'b1, hldc_pkg::CTRL_OFFSET, c);
            apb(1'b0, hldc_pkg::CTRL_OFFSET, 32'h0);
            chk("ctrl readback", rd, c);
            chk("contact", 32'(senseContactFour), 32'(c[7]));
            e = (k >= 1 && k <= 4) ? k - 1 : 0;
            chk("fixed rail", 32'(railMode), e);
        end
        apb(1'b1, hldc_pkg::CTRL_OFFSET, 32'h00000040);
        apb(1'b1, hldc_pkg::CTRL_OFFSET, 32'h00000070);
        t = 0;
        while (railMode !== 2'h0 && t < 60) tic();
        chk("step up", 32'(railMode), 32'h0);
        clipPresentPin <= 1'b0;
        clipLowerPin <= 1'b0;
        t = 0;
        while (railMode !== 2'h1 && t < 200) tic();
        chk("hold", 32'(t >= SD && t <= SD + 8), 32'h1);
        repeat (30) @(posedge clock);
        clipLowerPin <= 1'b1;
        repeat (4) @(posedge clock);
        clipLowerPin <= 1'b0;
        t = 0;
        while (railMode !== 2'h2 && t < 200) tic();
        chk("hold restart", 32'(t >= SD && t <= SD + 8), 32'h1);
        v = (rnd() & 32'h003f3f3f) | 32'h00101010;
        apb(1'b1, hldc_pkg::VOLUME_OFFSET, v);
        repeat (2) @(posedge clock);
        chk("direct volume", {8'h00, hpVolume, dacVolume, mixerVolume}, v);
        for (int r = 0; r < 16; r += 5) begin
            apb(1'b1, hldc_pkg::CTRL_OFFSET, {16'h0000, 4'(r), 4'(r), 8'h7e});
            v = {8'h00, v[23:16] + 8'h02, v[15:8] - 8'h02, v[7:0] + 8'h03};
            apb(1'b1, hldc_pkg::VOLUME_OFFSET, v);
            d = DLY[r];
            t = 0;
            while (mixerVolume !== v[7:0] && t < 4000) tic();
            chk("ramp time", 32'(t >= 16 * d - 8 && t <= 24 * d + 16), 32'h1);
            repeat (8) @(posedge clock);
            chk("ramp end", {8'h00, hpVolume, dacVolume, mixerVolume}, v);
        end
        apb(1'b1, hldc_pkg::CTRL_OFFSET, 32'h00000010);
        plugDetectPin <= 1'b1;
        repeat (20) @(posedge clock);
        chk("disabled plug", 32'(toneEnable), 32'h0);
        plugDetectPin <= 1'b0;
        // a plug pulse while frozen must never reach the synchronisers
        apb(1'b1, hldc_pkg::CTRL_OFFSET, 32'h00000011);
        clockEnable <= 1'b0;
        plugDetectPin <= 1'b1;
        repeat (12) @(posedge clock);
        plugDetectPin <= 1'b0;
        repeat (4) @(posedge clock);
        clockEnable <= 1'b1;
        repeat (12) @(posedge clock);
        chk("frozen plug", 32'(toneEnable), 32'h0);
        for (int i = 0; i < 3; i++) begin
            resAbove300Pin <= i == 2;
            resAbove22Pin <= i != 0;
            capHighPin <= i != 1;
            // both channels share one comparator set
            // power, mute, filter, bias live outside
            // contact bit from i[0], rail 100, ramps 0111 and 0001
            apb(1'b1, hldc_pkg::CTRL_OFFSET, {16'h0000, 4'h1, 4'h7, i[0], 7'h41});
            plugDetectPin <= 1'b1;
            t = 0;
            while (toneEnable !== 1'b1 && t < 20) tic();
            chk("detect start", 32'(toneEnable), 32'h1);
            if (i == 0) begin
                e = 32'(toneOutA);
                while (toneOutA === e[0] && t < 2000) tic();
                e = 32'(toneOutA);
                t = 0;
                while (toneOutA === e[0] && t < 2000) tic();
                chk("tone half", t, hldc_pkg::TONE_HALF_CYCLES);
            end
            t = 0;
            while (toneEnable === 1'b1 && t < 9000) tic();
            chk("cap phase", 32'(t > hldc_pkg::RES_MEAS_CYCLES + 100), 32'(i == 2));
            repeat (4) @(posedge clock);
            apb(1'b0, hldc_pkg::STATUS_OFFSET, 32'h0);
            chk("status", rd, {25'h0, 2'h3, 1'b0, 1'b1, i == 2, 2'(i)});
            apb(1'b1, hldc_pkg::STATUS_OFFSET, 32'h00000008);
            apb(1'b0, hldc_pkg::STATUS_OFFSET, 32'h0);
            chk("done clear", 32'(rd[3]), 32'h0);
            plugDetectPin <= 1'b0;
            repeat (8) @(posedge clock);
        end
        apb(1'b1, hldc_pkg::CTRL_OFFSET, 32'h00000010);
        repeat (4) @(posedge clock);
        chk("restored rail", 32'(railMode), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
